// ### verilog/dscg_regs.svh
// Purpose: Register offsets, field positions, reset values and codes of the gate
// Assumes: Included by bare name; definitions only
// Notes: Word aligned byte offsets on a 32-bit Wishbone bus
`ifndef DSCG_REGS_SVH
`define DSCG_REGS_SVH

`define DSCG_OFS_DIAG 8'h00
`define DSCG_OFS_CTRL 8'h04
`define DSCG_OFS_EXC 8'h08

// Diagnostic field, nine bits in the low bits of its word
`define DSCG_DIAG_W 9
`define DSCG_PAR_DIS_BIT 0
`define DSCG_CE_BIT 1
`define DSCG_HIT_BIT 2
`define DSCG_NMI_BIT 3
`define DSCG_SOFT_RST_BIT 4
`define DSCG_TLB_CONF_BIT 5
`define DSCG_BOOT_VEC_BIT 6

// Control word
`define DSCG_USE0_BIT 0
`define DSCG_USE1_BIT 1
`define DSCG_USE2_BIT 2
`define DSCG_XEN_BIT 3

// Exception word
`define DSCG_EXC_CODE_LSB 0
`define DSCG_EXC_CE_LSB 8

`define DSCG_BOOT_VEC_RST 1'h1
`define DSCG_USE_RST 3'h0
`define DSCG_XEN_RST 1'h0

`define DSCG_EXC_RI 5'h0A
`define DSCG_EXC_CPU 5'h0B
`define DSCG_EXC_FPE 5'h0F
`define DSCG_EXC_NONE 5'h00

`define DSCG_CP0 2'h0
`define DSCG_CP1 2'h1
`define DSCG_CP2 2'h2
`define DSCG_CP3 2'h3

`define DSCG_TLB_N 64

`endif

// ### verilog/dscg_pkg.sv
// Purpose: Types shared by the diagnostic status and coprocessor gate
// Assumes: Used only with explicit package scope
// Notes: Classes are decoded by the core before they reach the gate
package dscg_pkg;

  typedef enum logic [2:0] {
    DSCG_CLS_OTHER = 3'h0,
    DSCG_CLS_COP0 = 3'h1,
    DSCG_CLS_FP = 3'h2,
    DSCG_CLS_FP_SECOND = 3'h3,
    DSCG_CLS_FP_BC_CMP = 3'h4,
    DSCG_CLS_CMOVE_FPCOND = 3'h5,
    DSCG_CLS_THIRD_COPROC = 3'h6,
    DSCG_CLS_FOURTH_COPROC = 3'h7
  } dscg_class_t;

  typedef enum logic [1:0] {
    DSCG_MODE_KERNEL = 2'h0,
    DSCG_MODE_SUPER = 2'h1,
    DSCG_MODE_USER = 2'h2,
    DSCG_MODE_USER_ALT = 2'h3
  } dscg_mode_t;

  typedef enum logic [1:0] {
    DSCG_TLB_IDLE = 2'h0,
    DSCG_TLB_INVAL = 2'h1,
    DSCG_TLB_STORE = 2'h2
  } dscg_tlb_state_t;

  typedef struct packed {
    logic valid;
    dscg_class_t cls;
    logic [2:0] cond_sel;
    dscg_mode_t mode;
  } dscg_instr_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [4:0] code;
    logic [1:0] unit;
  } dscg_verdict_t;

endpackage

// ### verilog/dscg_gate.sv
// Purpose: Diagnostic status field and coprocessor usability gate
// Assumes: Core decodes instructions into classes; TLB supplies match vectors
// Notes: Wishbone classic slave, one wait state on every access
//
// Behaviour
// - Diagnostic field is nine bits holding cache and TLB self-test indications.
// - A TLB write matching another existing entry sets the conflict flag.
// - Conflicting entries, wired ones too, are invalidated before the new store.
// - Conflict flag is updated every TLB write; software reads it and clears it.
// - Reset, soft reset and NMI exceptions clear the conflict flag.
// - Soft reset and NMI set the indicator; origin bit is 1 for NMI.
// - Boot vector select picks normal vectors at 0, bootstrap vectors at 1.
// - Cache hit indicator records hit or miss of last secondary hit-invalidate.
// - Parity disable set suppresses cache parity and ECC exceptions.
// - Reserved diagnostic bits read zero; software writes zeros.
// - Three usability bits gate coprocessors 0 to 2; unusable access faults.
// - Kernel mode may always use coprocessor 0.
// - With floating point unusable every floating point instruction faults.
// - Second floating point opcode decodes as floating point with extended set.
// - Condition select above zero without extended set is unimplemented.
// - Conditional move on a floating condition faults when unit 1 is disabled.
// - Unit 2 instructions always fault; code depends on its usability bit.
// - Unit 3 operate without extended set is a reserved instruction.
// - User extended set enable makes extended instructions usable in user mode.
// - Coprocessor unusable faults report the referenced unit number.
`timescale 1ns/1ps
`include "dscg_regs.svh"

module dscg_gate #(
  parameter int TLB_N = `DSCG_TLB_N
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic tlb_wr_i, // TLB write request pulse
  input wire logic [TLB_N-1:0] tlb_match_i, // Entries the new entry would match
  output logic tlb_busy_o, // TLB write in progress
  output logic [TLB_N-1:0] tlb_inval_o, // Entries to invalidate, one cycle
  output logic tlb_store_o, // Store the new entry, one cycle
  input wire logic rst_exc_i, // Reset exception taken
  input wire logic soft_rst_exc_i, // Soft reset exception taken
  input wire logic nmi_exc_i, // Nonmaskable interrupt exception taken
  input wire logic cop_done_i, // Secondary hit-invalidate op finished
  input wire logic cop_hit_i, // Tag match with valid state
  input wire logic perr_i, // Cache parity or ECC error seen
  output logic perr_exc_o, // Parity or ECC exception request
  output logic boot_vector_select_o, // Vector base select
  input wire dscg_pkg::dscg_instr_t instr_i, // Decoded instruction to check
  output dscg_pkg::dscg_verdict_t verdict_o // Check result
);

  typedef struct packed {
    logic [`DSCG_DIAG_W-1:0] diag;
    logic [2:0] cu;
    logic xen;
    logic [4:0] last_code;
    logic [1:0] last_unit;
    dscg_pkg::dscg_tlb_state_t tlb_st;
    logic [TLB_N-1:0] inval;
    logic store;
    logic perr_exc;
    dscg_pkg::dscg_verdict_t verdict;
    logic ack;
    logic [31:0] rdata;
  } dscg_state_t;

  dscg_state_t st;
  dscg_state_t next_st;

  logic access;
  logic wr_diag;
  logic wr_ctrl;
  logic [31:0] rd_val;
  logic kernel;
  logic ext_on;
  dscg_pkg::dscg_verdict_t chk;

  // Writable diagnostic bits; the rest read zero
  localparam logic [`DSCG_DIAG_W-1:0] DIAG_WMASK =
    `DSCG_DIAG_W'((1 << `DSCG_PAR_DIS_BIT) | (1 << `DSCG_HIT_BIT) | (1 << `DSCG_NMI_BIT) |
    (1 << `DSCG_SOFT_RST_BIT) | (1 << `DSCG_TLB_CONF_BIT) | (1 << `DSCG_BOOT_VEC_BIT));

  assign access = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr_diag = access & wb_we_i & (wb_adr_i == `DSCG_OFS_DIAG);
  assign wr_ctrl = access & wb_we_i & (wb_adr_i == `DSCG_OFS_CTRL) & wb_sel_i[0];

  assign kernel = (instr_i.mode == dscg_pkg::DSCG_MODE_KERNEL);
  // Supervisor and kernel always run the extended set
  assign ext_on = (instr_i.mode != dscg_pkg::DSCG_MODE_USER &&
                   instr_i.mode != dscg_pkg::DSCG_MODE_USER_ALT) | st.xen;

  always_comb begin
    rd_val = 32'h0;
    unique case (wb_adr_i)
      `DSCG_OFS_DIAG: begin
        rd_val[`DSCG_DIAG_W-1:0] = st.diag & DIAG_WMASK;
      end
      `DSCG_OFS_CTRL: begin
        rd_val[`DSCG_USE0_BIT] = st.cu[0];
        rd_val[`DSCG_USE1_BIT] = st.cu[1];
        rd_val[`DSCG_USE2_BIT] = st.cu[2];
        rd_val[`DSCG_XEN_BIT] = st.xen;
      end
      `DSCG_OFS_EXC: begin
        rd_val[`DSCG_EXC_CODE_LSB +: 5] = st.last_code;
        rd_val[`DSCG_EXC_CE_LSB +: 2] = st.last_unit;
      end
      default: begin
        rd_val = 32'h0;
      end
    endcase
  end

  // Check is combinational from the request; verdict_o registers it one cycle later
  always_comb begin
    chk.valid = instr_i.valid;
    chk.fault = 1'b0;
    chk.code = `DSCG_EXC_NONE;
    chk.unit = `DSCG_CP0;
    unique case (instr_i.cls)
      dscg_pkg::DSCG_CLS_OTHER: begin
        chk.fault = 1'b0;
      end
      dscg_pkg::DSCG_CLS_COP0: begin
        if (!kernel && !st.cu[0]) begin
          chk.fault = 1'b1;
          chk.code = `DSCG_EXC_CPU;
          chk.unit = `DSCG_CP0;
        end
      end
      dscg_pkg::DSCG_CLS_FP, dscg_pkg::DSCG_CLS_CMOVE_FPCOND: begin
        if (!st.cu[1]) begin
          chk.fault = 1'b1;
          chk.code = `DSCG_EXC_CPU;
          chk.unit = `DSCG_CP1;
        end
      end
      dscg_pkg::DSCG_CLS_FP_BC_CMP: begin
        if (!st.cu[1]) begin
          chk.fault = 1'b1;
          chk.code = `DSCG_EXC_CPU;
          chk.unit = `DSCG_CP1;
        end else if (instr_i.cond_sel != 3'h0 && !ext_on) begin
          chk.fault = 1'b1;
          chk.code = `DSCG_EXC_FPE;
          chk.unit = `DSCG_CP1;
        end
      end
      dscg_pkg::DSCG_CLS_FP_SECOND, dscg_pkg::DSCG_CLS_FOURTH_COPROC: begin
        if (!ext_on) begin
          chk.fault = 1'b1;
          chk.code = `DSCG_EXC_RI;
          chk.unit = `DSCG_CP3;
        end else if (!st.cu[1]) begin
          chk.fault = 1'b1;
          chk.code = `DSCG_EXC_CPU;
          chk.unit = `DSCG_CP1;
        end
      end
      dscg_pkg::DSCG_CLS_THIRD_COPROC: begin
        chk.fault = 1'b1;
        chk.unit = `DSCG_CP2;
        chk.code = st.cu[2] ? `DSCG_EXC_RI : `DSCG_EXC_CPU;
      end
    endcase
    if (!instr_i.valid) begin
      chk.fault = 1'b0;
      chk.code = `DSCG_EXC_NONE;
      chk.unit = `DSCG_CP0;
    end
  end

  always_comb begin
    next_st = st;
    next_st.store = 1'b0;
    next_st.inval = '0;

    // Bus: one wait state, ack drops the cycle after it was given
    next_st.ack = access;
    if (access) begin
      next_st.rdata = rd_val;
    end
    if (wr_diag && wb_sel_i[0]) begin
      next_st.diag[7:0] = wb_dat_i[7:0] & DIAG_WMASK[7:0];
    end
    if (wr_diag && wb_sel_i[1]) begin
      next_st.diag[8] = wb_dat_i[8] & DIAG_WMASK[8];
    end
    if (wr_ctrl) begin
      next_st.cu = {wb_dat_i[`DSCG_USE2_BIT], wb_dat_i[`DSCG_USE1_BIT],
                    wb_dat_i[`DSCG_USE0_BIT]};
      next_st.xen = wb_dat_i[`DSCG_XEN_BIT];
    end

    // Hardware events follow the software write so they win a tie
    if (cop_done_i) begin
      next_st.diag[`DSCG_HIT_BIT] = cop_hit_i;
    end
    next_st.perr_exc = perr_i & ~st.diag[`DSCG_PAR_DIS_BIT];

    unique case (st.tlb_st)
      dscg_pkg::DSCG_TLB_IDLE: begin
        if (tlb_wr_i) begin
          next_st.diag[`DSCG_TLB_CONF_BIT] = |tlb_match_i;
          if (|tlb_match_i) begin
            next_st.inval = tlb_match_i;
            next_st.tlb_st = dscg_pkg::DSCG_TLB_INVAL;
          end else begin
            next_st.store = 1'b1;
            next_st.tlb_st = dscg_pkg::DSCG_TLB_STORE;
          end
        end
      end
      dscg_pkg::DSCG_TLB_INVAL: begin
        // Store only after the clash is gone
        next_st.store = 1'b1;
        next_st.tlb_st = dscg_pkg::DSCG_TLB_STORE;
      end
      dscg_pkg::DSCG_TLB_STORE: begin
        next_st.tlb_st = dscg_pkg::DSCG_TLB_IDLE;
      end
      default: begin
        next_st.tlb_st = dscg_pkg::DSCG_TLB_IDLE;
      end
    endcase

    if (soft_rst_exc_i || nmi_exc_i) begin
      next_st.diag[`DSCG_SOFT_RST_BIT] = 1'b1;
      next_st.diag[`DSCG_NMI_BIT] = nmi_exc_i;
      next_st.diag[`DSCG_BOOT_VEC_BIT] = `DSCG_BOOT_VEC_RST;
    end
    if (rst_exc_i) begin
      next_st.diag[`DSCG_SOFT_RST_BIT] = 1'b0;
      next_st.diag[`DSCG_NMI_BIT] = 1'b0;
      next_st.diag[`DSCG_BOOT_VEC_BIT] = `DSCG_BOOT_VEC_RST;
    end
    if (rst_exc_i || soft_rst_exc_i || nmi_exc_i) begin
      next_st.diag[`DSCG_TLB_CONF_BIT] = 1'b0;
    end

    next_st.verdict = chk;
    if (chk.fault) begin
      next_st.last_code = chk.code;
      next_st.last_unit = chk.unit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.diag[`DSCG_BOOT_VEC_BIT] <= `DSCG_BOOT_VEC_RST;
      st.cu <= `DSCG_USE_RST;
      st.xen <= `DSCG_XEN_RST;
      st.tlb_st <= dscg_pkg::DSCG_TLB_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign tlb_busy_o = (st.tlb_st != dscg_pkg::DSCG_TLB_IDLE);
  assign tlb_inval_o = st.inval;
  assign tlb_store_o = st.store;
  assign perr_exc_o = st.perr_exc;
  assign boot_vector_select_o = st.diag[`DSCG_BOOT_VEC_BIT];
  assign verdict_o = st.verdict;

endmodule

// ### tb/dscg_checker.sv
// Purpose: Port-level properties of the diagnostic status and coprocessor gate
// Assumes: Bound to every dscg_gate instance
// Notes: Register contents are judged by the bench, timing here
`timescale 1ns/1ps
`include "dscg_regs.svh"
module dscg_checker #(
  parameter int TLB_N = 4
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic tlb_wr_i, // TLB write request
  input wire logic [TLB_N-1:0] tlb_match_i, // Would-match entries
  input wire logic tlb_busy_o, // TLB write busy
  input wire logic [TLB_N-1:0] tlb_inval_o, // Invalidate vector
  input wire logic tlb_store_o, // Store pulse
  input wire logic perr_i, // Parity error seen
  input wire logic perr_exc_o, // Parity exception
  input wire dscg_pkg::dscg_instr_t instr_i, // Instruction in
  input wire dscg_pkg::dscg_verdict_t verdict_o // Verdict out
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wb_ack_once: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single cycle");
  a_tlb_inval_first: assert property ((tlb_wr_i && !tlb_busy_o && |tlb_match_i)
    |=> (tlb_inval_o == $past(tlb_match_i)) && !tlb_store_o ##1 tlb_store_o)
    else $error("conflict not invalidated before store");
  a_tlb_store_plain: assert property ((tlb_wr_i && !tlb_busy_o && !(|tlb_match_i))
    |=> tlb_store_o && tlb_inval_o == '0) else $error("plain TLB write mishandled");
  a_verdict_follows: assert property (verdict_o.valid ==
    ($past(instr_i.valid) && !$past(rst_i))) else $error("verdict not one cycle after");
  a_cop0_kernel: assert property ((instr_i.valid && instr_i.mode ==
    dscg_pkg::DSCG_MODE_KERNEL && instr_i.cls == dscg_pkg::DSCG_CLS_COP0)
    |=> !verdict_o.fault) else $error("kernel unit 0 access faulted");
  a_third_coproc_operate_faults: assert property ((instr_i.valid &&
    instr_i.cls == dscg_pkg::DSCG_CLS_THIRD_COPROC)
    |=> verdict_o.fault && verdict_o.unit == `DSCG_CP2)
    else $error("unit 2 access did not fault");
  a_fp_unit_one: assert property ((instr_i.valid && instr_i.cls == dscg_pkg::DSCG_CLS_FP)
    |=> !verdict_o.fault || (verdict_o.code == `DSCG_EXC_CPU && verdict_o.unit == `DSCG_CP1))
    else $error("floating point fault wrong");
  a_fault_code: assert property (verdict_o.fault |-> verdict_o.code inside
    {`DSCG_EXC_RI, `DSCG_EXC_CPU, `DSCG_EXC_FPE}) else $error("bad fault code");
  a_perr_cause: assert property (perr_exc_o |-> $past(perr_i))
    else $error("parity exception without error");
endmodule

bind dscg_gate dscg_checker #(.TLB_N(TLB_N)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tlb_wr_i(tlb_wr_i),
  .tlb_match_i(tlb_match_i), .tlb_busy_o(tlb_busy_o), .tlb_inval_o(tlb_inval_o),
  .tlb_store_o(tlb_store_o), .perr_i(perr_i), .perr_exc_o(perr_exc_o),
  .instr_i(instr_i), .verdict_o(verdict_o));

// ### tb/tb.sv
// Purpose: Self-checking bench for the gate
// Assumes: Outputs are read at the edge after they are launched
// Notes: TLB_N cut to 4 to keep vectors short
`timescale 1ns/1ps
module tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0;
  logic [31:0] rd;
  logic [31:0] q;
  logic ack, busy, store, pex, boot_vector_select;
  logic tw = 0;
  logic cd = 0;
  logic hit_in = 0;
  logic [3:0] sel = 4'hF;
  logic pe = 0;
  logic [2:0] ex = 0;
  logic [3:0] tm = 0;
  logic [3:0] inval;
  dscg_pkg::dscg_instr_t instr = '0;
  dscg_pkg::dscg_verdict_t vd;
  int err_total = 0;
  int total_checks = 0;

  always #50 clk_i = ~clk_i;

  dscg_gate #(.TLB_N(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .tlb_wr_i(tw), .tlb_match_i(tm), .tlb_busy_o(busy),
    .tlb_inval_o(inval), .tlb_store_o(store), .rst_exc_i(ex[0]), .soft_rst_exc_i(ex[1]),
    .nmi_exc_i(ex[2]), .cop_done_i(cd), .cop_hit_i(hit_in), .perr_i(pe), .perr_exc_o(pex),
    .boot_vector_select_o(boot_vector_select), .instr_i(instr), .verdict_o(vd));

  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task summarize;
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Called at a rising edge; read data lands in q
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 9);
    q = rd;
    chk({31'h0, ack}, 32'h1);
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0);
    chk(q, e);
  endtask

  task tlb(input logic [3:0] m);
    tw <= 1;
    tm <= m;
    @(posedge clk_i);
    tw <= 0;
    tm <= ~m;
    @(posedge clk_i);
    chk(inval, m);
    chk(store, m == 0);
    chk(busy, 1);
    if (m != 0) begin
      @(posedge clk_i);
      chk(store, 1);
    end
    @(posedge clk_i);
    chk(busy, 0);
  endtask

  task ev(input logic [2:0] v);
    ex <= v;
    @(posedge clk_i);
    ex <= 0;
    @(posedge clk_i);
  endtask

  task t_reset;
    rdchk(8'h00, 32'h40);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    rdchk(8'h0C, 32'h0);
    chk(boot_vector_select, 1);
    chk(vd, 0);
    // Writes with the low lane off must leave both words alone
    sel <= 4'hE;
    wb(1, 8'h00, 32'h0);
    wb(1, 8'h04, 32'hF);
    sel <= 4'hF;
    rdchk(8'h00, 32'h40);
    rdchk(8'h04, 32'h0);
  endtask

  task t_tlb;
    tlb(4'h5);
    rdchk(8'h00, 32'h60);
    tlb(4'h0);
    rdchk(8'h00, 32'h40);
    tlb(4'hA);
    wb(1, 8'h00, 32'h40);
    rdchk(8'h00, 32'h40);
  endtask

  task t_exc;
    wb(1, 8'h00, 32'h0);
    chk(boot_vector_select, 0);
    tlb(4'h3);
    ev(3'h2);
    rdchk(8'h00, 32'h50);
    tlb(4'h3);
    ev(3'h4);
    rdchk(8'h00, 32'h58);
    tlb(4'h3);
    ev(3'h1);
    rdchk(8'h00, 32'h40);
  endtask

  task t_cache(input logic h, input logic [31:0] e);
    cd <= 1;
    hit_in <= h;
    @(posedge clk_i);
    cd <= 0;
    hit_in <= ~h;
    @(posedge clk_i);
    rdchk(8'h00, e);
  endtask

  task t_perr;
    wb(1, 8'h00, 32'hFFFFFE41);
    rdchk(8'h00, 32'h41);
    pe <= 1;
    repeat (2) @(posedge clk_i);
    chk(pex, 0);
    wb(1, 8'h00, 32'h40);
    @(posedge clk_i);
    chk(pex, 1);
    pe <= 0;
  endtask

  // Class codes: 1 unit0, 2 fp, 3 fp second, 4 fp branch/compare, 5 cond move, 6 unit2, 7 unit3
  task cp(input logic [3:0] c, input logic [2:0] k, input logic [2:0] s, input logic [1:0] m,
          input logic f, input logic [4:0] e, input logic [1:0] u);
    wb(1, 8'h04, {28'h0, c});
    instr <= {1'b1, k, s, m};
    @(posedge clk_i);
    instr <= '0;
    @(posedge clk_i);
    chk({vd.valid, vd.fault}, {1'b1, f});
    if (f) begin
      chk(vd.code, e);
      if (e != 5'h0F) chk(vd.unit, u);
      wb(0, 8'h08, 32'h0);
      chk(q[4:0], e);
      if (e != 5'h0F) chk(q[9:8], u);
    end
  endtask

  task t_cop;
    cp(4'h0, 3'h1, 3'h0, 2'h0, 1'b0, 5'h00, 2'h0);
    cp(4'h0, 3'h1, 3'h0, 2'h2, 1'b1, 5'h0B, 2'h0);
    cp(4'h0, 3'h2, 3'h0, 2'h0, 1'b1, 5'h0B, 2'h1);
    cp(4'h0, 3'h4, 3'h0, 2'h0, 1'b1, 5'h0B, 2'h1);
    cp(4'h0, 3'h5, 3'h0, 2'h2, 1'b1, 5'h0B, 2'h1);
    cp(4'h0, 3'h6, 3'h0, 2'h2, 1'b1, 5'h0B, 2'h2);
    cp(4'h0, 3'h7, 3'h0, 2'h2, 1'b1, 5'h0A, 2'h3);
    cp(4'h0, 3'h3, 3'h0, 2'h3, 1'b1, 5'h0A, 2'h3);
    cp(4'h0, 3'h0, 3'h0, 2'h2, 1'b0, 5'h00, 2'h0);
    cp(4'h7, 3'h1, 3'h0, 2'h2, 1'b0, 5'h00, 2'h0);
    cp(4'h7, 3'h2, 3'h0, 2'h2, 1'b0, 5'h00, 2'h0);
    cp(4'h7, 3'h6, 3'h0, 2'h0, 1'b1, 5'h0A, 2'h2);
    cp(4'h7, 3'h4, 3'h3, 2'h2, 1'b1, 5'h0F, 2'h0);
    cp(4'h7, 3'h4, 3'h7, 2'h1, 1'b0, 5'h00, 2'h0);
    cp(4'h7, 3'h7, 3'h0, 2'h3, 1'b1, 5'h0A, 2'h3);
    cp(4'h7, 3'h5, 3'h0, 2'h2, 1'b0, 5'h00, 2'h0);
    cp(4'hF, 3'h4, 3'h7, 2'h2, 1'b0, 5'h00, 2'h0);
    cp(4'hF, 3'h3, 3'h0, 2'h2, 1'b0, 5'h00, 2'h0);
    cp(4'hD, 3'h3, 3'h0, 2'h3, 1'b1, 5'h0B, 2'h1);
    rdchk(8'h04, 32'hD);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_tlb();
    t_exc();
    t_cache(1'b1, 32'h44);
    t_cache(1'b0, 32'h40);
    t_perr();
    t_cop();
    summarize();
  end
endmodule
